// file: core/msc_regs.sv
// Metering status and configuration register bank
module msc_regs
  import msc_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // Host register port
  input  wire logic [15:0]       REG_ADDR_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  input  wire logic [31:0]       REG_WDATA_I,
  output logic      [31:0]       REG_RDATA_O,
  output logic                   REG_RVALID_O,
  // Datapath measurements
  input  msc_meas_s              MEAS_I,
  input  wire logic [31:0]       CHECKSUM_I,
  input  wire logic              CHECKSUM_VLD_I,
  // Datapath configuration
  output msc_cfg_s               CFG_O,
  output logic [PHASES-1:0][23:0] EFF_VRMS_O
);

  // Configuration registers and checksum
  logic [23:0] nom_v_q;
  logic [15:0] line_cyc_q;
  logic [15:0] zx_tout_q;
  logic [15:0] comp_q;
  logic [15:0] gain_q;
  logic [15:0] pulse_q;
  logic [31:0] chk_q;

  // Read path
  logic [31:0] raw_d;
  msc_fmt_e    fmt_d;
  logic [31:0] word_d;
  logic [31:0] rdata_q;
  logic        rvalid_q;

  // Write decode and per-phase substitute enables
  wire logic wr_nom;
  wire logic wr_line;
  wire logic wr_zx;
  wire logic wr_comp;
  wire logic wr_gain;
  wire logic wr_pulse;
  wire logic [PHASES-1:0] sub_en;

  assign wr_nom   = REG_WR_I && (REG_ADDR_I == ADDR_NOM_V);
  assign wr_line  = REG_WR_I && (REG_ADDR_I == ADDR_LINE_CYC);
  assign wr_zx    = REG_WR_I && (REG_ADDR_I == ADDR_ZX_TOUT);
  assign wr_comp  = REG_WR_I && (REG_ADDR_I == ADDR_COMP_CFG);
  assign wr_gain  = REG_WR_I && (REG_ADDR_I == ADDR_AMP_GAIN);
  assign wr_pulse = REG_WR_I && (REG_ADDR_I == ADDR_PULSE_CFG);

  assign sub_en = comp_q[VSUB_EN_LSB +: PHASES];

  // Nominal voltage
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      nom_v_q <= NOM_V_RST;
    end else if (wr_nom) begin
      nom_v_q <= REG_WDATA_I[23:0];
    end
  end

  // Line cycle count
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      line_cyc_q <= LINE_CYC_RST;
    end else if (wr_line) begin
      line_cyc_q <= REG_WDATA_I[15:0];
    end
  end

  // Zero-crossing timeout
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      zx_tout_q <= ZX_TOUT_RST;
    end else if (wr_zx) begin
      zx_tout_q <= REG_WDATA_I[15:0];
    end
  end

  // Computation configuration
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      comp_q <= COMP_CFG_RST;
    end else if (wr_comp) begin
      comp_q <= REG_WDATA_I[15:0];
    end
  end

  // Amplifier gains
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      gain_q <= AMP_GAIN_RST;
    end else if (wr_gain) begin
      gain_q <= REG_WDATA_I[15:0];
    end
  end

  // Pulse output configuration
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pulse_q <= PULSE_CFG_RST;
    end else if (wr_pulse) begin
      pulse_q <= REG_WDATA_I[15:0];
    end
  end

  // Checksum, refreshed by the datapath only
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      chk_q <= CHECKSUM_RST;
    end else if (CHECKSUM_VLD_I) begin
      chk_q <= CHECKSUM_I;
    end
  end

  // Writes to reserved addresses fall through unused
  wire logic wr_rsv;
  assign wr_rsv = REG_WR_I && (
    ((REG_ADDR_I >= ADDR_RSV0_LO) && (REG_ADDR_I <= ADDR_RSV0_HI)) ||
    ((REG_ADDR_I >= ADDR_RSV1_LO) && (REG_ADDR_I <= ADDR_RSV1_HI)) ||
    ((REG_ADDR_I >= ADDR_RSV2_LO) && (REG_ADDR_I <= ADDR_RSV2_HI)));

  // Host writes aimed at read-only registers
  wire logic wr_ro;
  assign wr_ro = REG_WR_I && (
    (REG_ADDR_I == ADDR_VA_A) || (REG_ADDR_I == ADDR_VA_B) ||
    (REG_ADDR_I == ADDR_VA_C) || (REG_ADDR_I == ADDR_CHECKSUM));

  // Read select
  always_comb begin
    raw_d = 32'h00000000;
    fmt_d = FMT_RAW;
    if (REG_ADDR_I == ADDR_VA_A) begin
      raw_d = {8'h00, MEAS_I.va[0]};
      fmt_d = FMT_SE24;
    end else if (REG_ADDR_I == ADDR_VA_B) begin
      raw_d = {8'h00, MEAS_I.va[1]};
      fmt_d = FMT_SE24;
    end else if (REG_ADDR_I == ADDR_VA_C) begin
      raw_d = {8'h00, MEAS_I.va[2]};
      fmt_d = FMT_SE24;
    end else if (REG_ADDR_I == ADDR_CHECKSUM) begin
      raw_d = chk_q;
    end else if (REG_ADDR_I == ADDR_NOM_V) begin
      raw_d = {8'h00, nom_v_q};
      fmt_d = FMT_ZP24;
    end else if (REG_ADDR_I == ADDR_PEAK_STAT) begin
      raw_d = {16'h0000, MEAS_I.peak};
    end else if (REG_ADDR_I == ADDR_DELAY0) begin
      raw_d = {16'h0000, MEAS_I.delay[0]};
    end else if (REG_ADDR_I == ADDR_DELAY1) begin
      raw_d = {16'h0000, MEAS_I.delay[1]};
    end else if (REG_ADDR_I == ADDR_DELAY2) begin
      raw_d = {16'h0000, MEAS_I.delay[2]};
    end else if (REG_ADDR_I == ADDR_PERIOD) begin
      raw_d = {16'h0000, MEAS_I.period};
    end else if (REG_ADDR_I == ADDR_IDLE_LOAD) begin
      raw_d = {16'h0000, MEAS_I.idle};
    end else if (REG_ADDR_I == ADDR_LINE_CYC) begin
      raw_d = {16'h0000, line_cyc_q};
    end else if (REG_ADDR_I == ADDR_ZX_TOUT) begin
      raw_d = {16'h0000, zx_tout_q};
    end else if (REG_ADDR_I == ADDR_COMP_CFG) begin
      raw_d = {16'h0000, comp_q};
    end else if (REG_ADDR_I == ADDR_AMP_GAIN) begin
      raw_d = {16'h0000, gain_q};
    end else if (REG_ADDR_I == ADDR_PULSE_CFG) begin
      raw_d = {16'h0000, pulse_q};
    end
  end

  msc_rdfmt u_rdfmt (
    .raw_i  (raw_d),
    .fmt_i  (fmt_d),
    .word_o (word_d)
  );

  // Read answer one cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_q  <= RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= REG_RD_I ? word_d : rdata_q;
      rvalid_q <= REG_RD_I;
    end
  end

  assign REG_RDATA_O  = rdata_q;
  assign REG_RVALID_O = rvalid_q;

  // Nominal voltage substitution
  msc_vsel u_vsel (
    .clk_i    (CLK_I),
    .rst_i    (RST_I),
    .sub_en_i (sub_en),
    .nom_v_i  (nom_v_q),
    .meas_v_i (MEAS_I.vrms),
    .eff_v_o  (EFF_VRMS_O)
  );

  assign CFG_O.line_cycle = line_cyc_q;
  assign CFG_O.zx_tout    = zx_tout_q;
  assign CFG_O.comp       = comp_q;
  assign CFG_O.gain       = gain_q;
  assign CFG_O.pulse      = pulse_q;
  assign CFG_O.nom_v      = nom_v_q;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  wire logic rd_va_a;
  wire logic rd_va_c;
  wire logic rd_chk;
  wire logic rd_nom;
  assign rd_va_a = REG_RD_I && (REG_ADDR_I == ADDR_VA_A);
  assign rd_va_c = REG_RD_I && (REG_ADDR_I == ADDR_VA_C);
  assign rd_chk  = REG_RD_I && (REG_ADDR_I == ADDR_CHECKSUM);
  assign rd_nom  = REG_RD_I && (REG_ADDR_I == ADDR_NOM_V);

  vsub_pick_a: assert property (
    sub_en[0] |=> EFF_VRMS_O[0] == $past(nom_v_q))
    else $error("phase A substitute not taken");

  vmeas_pass_a: assert property (
    !sub_en[2] |=> EFF_VRMS_O[2] == $past(MEAS_I.vrms[2]))
    else $error("phase C measured voltage not passed");

  nom_reset_a: assert property (
    $past(RST_I) |-> (nom_v_q == NOM_V_RST) && (gain_q == AMP_GAIN_RST))
    else $error("nominal voltage or gain not reset");

  nom_write_a: assert property (
    wr_nom |=> nom_v_q == $past(REG_WDATA_I[23:0]))
    else $error("nominal voltage write lost");

  rsv_quiet_a: assert property (
    wr_rsv |=> $stable(CFG_O))
    else $error("reserved write changed configuration");

  va_sext_a: assert property (
    rd_va_a |=> REG_RVALID_O &&
      (REG_RDATA_O == {{8{$past(MEAS_I.va[0][23])}}, $past(MEAS_I.va[0])}))
    else $error("phase A apparent power read wrong");

  vc_sign_a: assert property (
    rd_va_c ##0 MEAS_I.va[2][23] |=> REG_RDATA_O[31:24] == 8'hFF)
    else $error("negative apparent power not sign extended");

  chk_read_a: assert property (
    rd_chk |=> REG_RDATA_O == $past(chk_q))
    else $error("checksum read wrong");

  chk_reset_a: assert property (
    $past(RST_I) |-> chk_q == CHECKSUM_RST)
    else $error("checksum default wrong");

  line_reset_a: assert property (
    $past(RST_I) |-> line_cyc_q == LINE_CYC_RST)
    else $error("line cycle count not all ones");

  gain_hold_a: assert property (
    !wr_gain |=> $stable(gain_q))
    else $error("gain changed without write");

  nom_zpad_a: assert property (
    rd_nom |=> REG_RDATA_O[31:24] == 8'h00)
    else $error("nominal voltage not zero padded");

  ro_quiet_a: assert property (
    wr_ro |=> $stable(CFG_O))
    else $error("read-only write changed configuration");

  chk_hold_a: assert property (
    !CHECKSUM_VLD_I |=> $stable(chk_q))
    else $error("checksum changed without load");

  line_write_a: assert property (
    wr_line |=> line_cyc_q == $past(REG_WDATA_I[15:0]))
    else $error("line cycle count write lost");

  gain_write_a: assert property (
    wr_gain |=> gain_q == $past(REG_WDATA_I[15:0]))
    else $error("gain write lost");

  sub_pick_c_a: assert property (
    sub_en[2] |=> EFF_VRMS_O[2] == $past(nom_v_q))
    else $error("phase C substitute not taken");

  va_read_c: cover property (rd_va_a ##1 REG_RVALID_O);
  sub_use_c: cover property (wr_nom ##1 sub_en[1]);
  ro_write_c: cover property (wr_ro);

endmodule

// file: core/msc_pkg.sv
// Package: register map, reset values and carrier types of the metering register bank
package msc_pkg;

  localparam int PHASES = 3;

  // Register addresses
  localparam logic [15:0] ADDR_VA_A       = 16'hE519;
  localparam logic [15:0] ADDR_VA_B       = 16'hE51A;
  localparam logic [15:0] ADDR_VA_C       = 16'hE51B;
  localparam logic [15:0] ADDR_CHECKSUM   = 16'hE51F;
  localparam logic [15:0] ADDR_NOM_V      = 16'hE520;
  localparam logic [15:0] ADDR_RSV0_LO    = 16'hE521;
  localparam logic [15:0] ADDR_RSV0_HI    = 16'hE52E;
  localparam logic [15:0] ADDR_PEAK_STAT  = 16'hE600;
  localparam logic [15:0] ADDR_DELAY0     = 16'hE601;
  localparam logic [15:0] ADDR_DELAY1     = 16'hE602;
  localparam logic [15:0] ADDR_DELAY2     = 16'hE603;
  localparam logic [15:0] ADDR_RSV1_LO    = 16'hE604;
  localparam logic [15:0] ADDR_RSV1_HI    = 16'hE606;
  localparam logic [15:0] ADDR_PERIOD     = 16'hE607;
  localparam logic [15:0] ADDR_IDLE_LOAD  = 16'hE608;
  localparam logic [15:0] ADDR_RSV2_LO    = 16'hE609;
  localparam logic [15:0] ADDR_RSV2_HI    = 16'hE60B;
  localparam logic [15:0] ADDR_LINE_CYC   = 16'hE60C;
  localparam logic [15:0] ADDR_ZX_TOUT    = 16'hE60D;
  localparam logic [15:0] ADDR_COMP_CFG   = 16'hE60E;
  localparam logic [15:0] ADDR_AMP_GAIN   = 16'hE60F;
  localparam logic [15:0] ADDR_PULSE_CFG  = 16'hE610;

  // Values after reset
  localparam logic [31:0] CHECKSUM_RST    = 32'h33666787;
  localparam logic [23:0] NOM_V_RST       = 24'h000000;
  localparam logic [15:0] LINE_CYC_RST    = 16'hFFFF;
  localparam logic [15:0] ZX_TOUT_RST     = 16'hFFFF;
  localparam logic [15:0] COMP_CFG_RST    = 16'h01FF;
  localparam logic [15:0] AMP_GAIN_RST    = 16'h0000;
  localparam logic [15:0] PULSE_CFG_RST   = 16'h0E88;
  localparam logic [31:0] RDATA_RST       = 32'h00000000;

  // Field position of per-phase substitute enables in computation_config
  localparam int VSUB_EN_LSB = 9;

  // Read word format
  typedef enum logic [2:0] {
    FMT_SE24 = 3'b001,
    FMT_ZP24 = 3'b010,
    FMT_RAW  = 3'b100
  } msc_fmt_e;

  // Live measurements from the datapath
  typedef struct packed {
    logic [PHASES-1:0][23:0] va;
    logic [PHASES-1:0][23:0] vrms;
    logic [15:0]             peak;
    logic [PHASES-1:0][15:0] delay;
    logic [15:0]             period;
    logic [15:0]             idle;
  } msc_meas_s;

  // Configuration words towards the datapath
  typedef struct packed {
    logic [15:0] line_cycle;
    logic [15:0] zx_tout;
    logic [15:0] comp;
    logic [15:0] gain;
    logic [15:0] pulse;
    logic [23:0] nom_v;
  } msc_cfg_s;

endpackage

// file: core/msc_vsel.sv
// Per-phase choice between measured and nominal rms voltage
module msc_vsel
  import msc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Selection inputs
  input  wire logic [PHASES-1:0]        sub_en_i,
  input  wire logic [23:0]              nom_v_i,
  input  wire logic [PHASES-1:0][23:0]  meas_v_i,
  // Effective voltage
  output logic      [PHASES-1:0][23:0]  eff_v_o
);

  genvar g;
  wire logic [PHASES-1:0][23:0] eff_d;

  generate
    for (g = 0; g < PHASES; g++) begin : g_phase
      assign eff_d[g] = sub_en_i[g] ? nom_v_i : meas_v_i[g];
    end
  endgenerate

  // One register for all phases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eff_v_o <= {PHASES{NOM_V_RST}};
    end else begin
      eff_v_o <= eff_d;
    end
  end

endmodule

// file: core/msc_rdfmt.sv
// Widening of register contents to the host-port word
module msc_rdfmt
  import msc_pkg::*;
(
  // Raw value and its format
  input  wire logic [31:0] raw_i,
  input  msc_fmt_e         fmt_i,
  // Host word
  output logic      [31:0] word_o
);

  function automatic logic [31:0] widen(input logic [31:0] v, input msc_fmt_e f);
    logic [31:0] r;
    r = v;
    case (f)
      FMT_SE24: r = {{8{v[23]}}, v[23:0]};
      FMT_ZP24: r = {8'h00, v[23:0]};
      default:  r = v;
    endcase
    return r;
  endfunction

  assign word_o = widen(raw_i, fmt_i);

endmodule

// file: test/msc_host.sv
// Host model driving the register port strobes
module msc_host
  import msc_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Register port
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_o  = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 32'h00000000;
  end

  // Reserved holes of the map
  function automatic logic is_rsv(input logic [15:0] a);
    return (a >= ADDR_RSV0_LO && a <= ADDR_RSV0_HI) ||
           (a >= ADDR_RSV1_LO && a <= ADDR_RSV1_HI) ||
           (a >= ADDR_RSV2_LO && a <= ADDR_RSV2_HI);
  endfunction

  // One strobe cycle, none for writes to reserved holes; released address and data lines show inverted values
  task automatic access(input logic [15:0] a, input logic w, input logic [31:0] d);
    if (w && is_rsv(a)) return;
    @(posedge clk_i);
    #1;
    addr_o  = a;
    wr_o    = w;
    rd_o    = !w;
    wdata_o = w ? d : ~wdata_o;
    @(posedge clk_i);
    #1;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~wdata_o;
  endtask
endmodule

// file: test/msc_regs_bench.sv
// Self-checking bench of the metering register bank
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); bad_count++; end end
module msc_regs_bench
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk;
  logic                    rst;
  logic [15:0]             addr;
  logic                    wr;
  logic                    rd;
  logic [31:0]             wdata;
  logic [31:0]             rdata;
  logic                    rvalid;
  msc_meas_s               meas;
  logic [31:0]             cks;
  logic                    cks_vld;
  msc_cfg_s                cfg;
  logic [PHASES-1:0][23:0] eff;
  logic [31:0]             exp_q[$];
  logic [31:0]             exp_v;
  logic [31:0]             d;
  logic [23:0]             nv;
  int                      seed = 32'h834BE1C8;
  int                      bad_count = 0;
  int                      n_checks = 0;
  logic [15:0] rw_a[6] = '{ADDR_LINE_CYC, ADDR_ZX_TOUT, ADDR_COMP_CFG, ADDR_AMP_GAIN,
                           ADDR_PULSE_CFG, ADDR_NOM_V};
  logic [31:0] rw_r[6] = '{{16'h0, LINE_CYC_RST}, {16'h0, ZX_TOUT_RST}, {16'h0, COMP_CFG_RST},
                           {16'h0, AMP_GAIN_RST}, {16'h0, PULSE_CFG_RST}, {8'h0, NOM_V_RST}};
  logic [31:0] rw_m[6] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
                           32'h0000FFFF, 32'h00FFFFFF};
  localparam int       MEAS_W  = $bits(msc_meas_s);
  localparam msc_cfg_s CFG_RST = {LINE_CYC_RST, ZX_TOUT_RST, COMP_CFG_RST, AMP_GAIN_RST,
                                  PULSE_CFG_RST, NOM_V_RST};

  msc_regs i_msc_regs (
    .CLK_I          (clk),
    .RST_I          (rst),
    .REG_ADDR_I     (addr),
    .REG_WR_I       (wr),
    .REG_RD_I       (rd),
    .REG_WDATA_I    (wdata),
    .REG_RDATA_O    (rdata),
    .REG_RVALID_O   (rvalid),
    .MEAS_I         (meas),
    .CHECKSUM_I     (cks),
    .CHECKSUM_VLD_I (cks_vld),
    .CFG_O          (cfg),
    .EFF_VRMS_O     (eff)
  );

  msc_host i_msc_host (
    .clk_i   (clk),
    .addr_o  (addr),
    .wr_o    (wr),
    .rd_o    (rd),
    .wdata_o (wdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_msc_host.access(a, 1'b0, 32'h00000000);
  endtask

  // Read data monitor, oldest note first
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("CHECK FAILED rdata exp none got %h", rdata);
        bad_count++;
      end else begin
        exp_v = exp_q.pop_front();
        `CHK("rdata", exp_v, rdata)
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    rst     = 1'b1;
    meas    = MEAS_W'({8{$random(seed)}});
    cks     = 32'h00000000;
    cks_vld = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("cfg", CFG_RST, cfg)
    rd_chk(ADDR_CHECKSUM, CHECKSUM_RST);
    for (int i = 0; i < 6; i++) rd_chk(rw_a[i], rw_r[i]);
    // Random writes read back at register width
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      d[23] = 1'b1;
      i_msc_host.access(rw_a[i], 1'b1, d);
      rd_chk(rw_a[i], d & rw_m[i]);
    end
    // Apparent power of both signs
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < PHASES; p++) begin
        meas.va[p] = 24'($random(seed));
        meas.va[p][23] = k[0];
        rd_chk(ADDR_VA_A + 16'(p), {{8{meas.va[p][23]}}, meas.va[p]});
      end
    end
    i_msc_host.access(ADDR_VA_A, 1'b1, 32'h00000000);
    rd_chk(ADDR_VA_A, {{8{meas.va[0][23]}}, meas.va[0]});
    rd_chk(ADDR_PEAK_STAT, {16'h0000, meas.peak});
    rd_chk(ADDR_PERIOD, {16'h0000, meas.period});
    for (int p = 0; p < PHASES; p++) rd_chk(ADDR_DELAY0 + 16'(p), {16'h0000, meas.delay[p]});
    rd_chk(ADDR_IDLE_LOAD, {16'h0000, meas.idle});
    rd_chk(16'hE530, 32'h00000000);
    // Nominal voltage substitution per phase
    for (int m = 0; m < 8; m++) begin
      nv = 24'($random(seed));
      i_msc_host.access(ADDR_NOM_V, 1'b1, {8'hA5, nv});
      i_msc_host.access(ADDR_COMP_CFG, 1'b1, {16'h0000, 4'h0, 3'(m), 9'h1FF});
      repeat (2) @(posedge clk);
      #1;
      for (int p = 0; p < PHASES; p++) begin
        `CHK("eff_vrms", (m[p] ? nv : meas.vrms[p]), eff[p])
      end
    end
    // Mid-run reset restores every default
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("cfg_rst", CFG_RST, cfg)
    `CHK("eff_rst", {PHASES{NOM_V_RST}}, eff)
    i_msc_host.access(ADDR_CHECKSUM, 1'b1, ~CHECKSUM_RST);
    rd_chk(ADDR_CHECKSUM, CHECKSUM_RST);
    // Checksum reload from the datapath
    d = $random(seed);
    cks = d;
    cks_vld = 1'b1;
    @(posedge clk);
    #1;
    cks_vld = 1'b0;
    rd_chk(ADDR_CHECKSUM, d);
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) bad_count++;
    print_verdict();
  end
endmodule
